// [ssp_pkg.sv]
package ssp_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFF_STATUS = 8'h94;
    localparam logic [7:0] OFF_CTRL = 8'h98;
    localparam logic [7:0] OFF_BUF = 8'h9C;
    localparam logic [7:0] OFF_IRQ_STS = 8'hA0;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hA4;
    // Status register fields.
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_BF = 0;
    // Control register fields.
    localparam int CT_WCOL = 7;
    localparam int CT_OV = 6;
    localparam int CT_EN = 5;
    localparam int CT_CKP = 4;
    localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;
    // Interrupt status and mask bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OV = 1;
    localparam int IRQ_WCOL = 2;
    // Reset values.
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [2:0] PIN_RST = 3'h4;
    // Master clock half period base in aclk cycles; last master tick and last bit index as counts.
    localparam logic [4:0] MST_HALF_BASE = 5'h02;
    localparam logic [4:0] MST_LAST_TICK = 5'h10;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {MST_IDLE, MST_RUN} ssp_mst_e;
endpackage : ssp_pkg

// [ssp_sync.sv]
`timescale 1ns/100ps
module ssp_sync
    import ssp_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // A change is only taken once the second and third stages agree.
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic out_q;
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                s1_q <= RST[i];
                s2_q <= RST[i];
                s3_q <= RST[i];
                out_q <= RST[i];
            end
            else
            begin
                s1_q <= din[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q)
                    out_q <= s3_q;
            end
        end
        assign dout[i] = out_q;
    end
endmodule : ssp_sync

// [ssp_spi_core.sv]
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module ssp_spi_core
    import ssp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic ss_n_i
);
    logic [1:0] cfg_q;
    logic bf_q;
    logic [7:0] ctrl_q;
    logic [7:0] buf_q;
    logic [7:0] shreg_q;
    logic [2:0] sts_q;
    logic [2:0] mask_q;
    logic sdo_q;
    logic [2:0] bit_cnt_q;
    ssp_mst_e mst_q;
    logic [4:0] tick_q;
    logic [4:0] div_q;
    logic sck_q;
    logic pend_q;
    logic sck_prev_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic sck_s;
    logic sdi_s;
    logic ss_n_s;

    ssp_sync #(.W(3), .RST(PIN_RST)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({ss_n_i, sdi_i, sck_i}),
        .dout({ss_n_s, sdi_s, sck_s})
    );

    // Configuration decode.
    wire en = ctrl_q[CT_EN];
    wire clock_idle_polarity = ctrl_q[CT_CKP];
    wire [3:0] mode = ctrl_q[3:0];
    wire cke = cfg_q[0];
    wire sample_point_select = cfg_q[1];
    wire slave_mode = (mode == MODE_SLAVE_SS) || (mode == MODE_SLAVE_NOSS);
    wire use_ss = (mode == MODE_SLAVE_SS);
    wire master = en & ~slave_mode;
    wire s_act = en & slave_mode & (~use_ss | ~ss_n_s);
    wire [4:0] half_len = 5'(MST_HALF_BASE << mode[1:0]);

    // Bus decode. Address and data are taken together, so either order works.
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    wire wr_lane = wr_go & s_axi_wstrb[0];
    wire wsel_status = wr_lane & (s_axi_awaddr == OFF_STATUS);
    wire wsel_ctrl = wr_lane & (s_axi_awaddr == OFF_CTRL);
    wire wsel_buf = wr_lane & (s_axi_awaddr == OFF_BUF);
    wire wsel_sts = wr_lane & (s_axi_awaddr == OFF_IRQ_STS);
    wire wsel_mask = wr_lane & (s_axi_awaddr == OFF_IRQ_MASK);
    wire wr_hit = (s_axi_awaddr == OFF_STATUS) || (s_axi_awaddr == OFF_CTRL)
        || (s_axi_awaddr == OFF_BUF) || (s_axi_awaddr == OFF_IRQ_STS)
        || (s_axi_awaddr == OFF_IRQ_MASK);
    wire rd_go = s_axi_arvalid & ~rvalid_q;
    wire rd_buf = rd_go & (s_axi_araddr == OFF_BUF);
    wire [7:0] wbyte = s_axi_wdata[7:0];

    // Master clock engine.
    wire running = (mst_q == MST_RUN);
    wire tick = running & (div_q == 5'h00);
    wire toggle = tick & (tick_q != MST_LAST_TICK);
    wire m_lead = toggle & ~tick_q[0];
    wire m_trail = toggle & tick_q[0];

    // Slave clock edges come from the filtered pin.
    wire s_edge = s_act & (sck_s != sck_prev_q);
    wire s_lead = s_edge & (sck_s != clock_idle_polarity);
    wire s_trail = s_edge & (sck_s == clock_idle_polarity);

    wire lead = master ? m_lead : s_lead;
    wire trail = master ? m_trail : s_trail;
    wire sample_edge = cke ? lead : trail;
    wire shift_edge = cke ? trail : lead;
    // Late sampling lands one half period later, at the end of the bit time.
    wire do_sample = (master & sample_point_select) ? (tick & pend_q) : sample_edge;
    wire done = do_sample & (bit_cnt_q == LAST_BIT);
    wire [7:0] shreg_next = {shreg_q[6:0], sdi_s};
    // Late sampling lands on the shift edge, so send the bit that the sample uncovers.
    wire next_out = do_sample ? shreg_q[6] : shreg_q[7];

    wire busy = running | (bit_cnt_q != 3'h0);
    wire collide = wsel_buf & busy;
    wire load = wsel_buf & ~busy;
    // A read in the same cycle frees the buffer, so the new word still lands.
    wire accept = done & (~bf_q | rd_buf);
    wire ovf = done & bf_q & ~rd_buf;
    wire [2:0] sts_set = {collide, ovf, done};

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign sck_o = sck_q;
    assign sck_oe = master;
    assign sdo_o = sdo_q;
    assign sdo_oe = master | s_act;
    assign irq = |(sts_q & mask_q);

    wire [7:0] status_rd = {cfg_q, 5'h00, bf_q};
    wire rd_hit = (s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_CTRL)
        || (s_axi_araddr == OFF_BUF) || (s_axi_araddr == OFF_IRQ_STS)
        || (s_axi_araddr == OFF_IRQ_MASK);
    wire [7:0] rd_mux =
        (s_axi_araddr == OFF_STATUS) ? status_rd :
        (s_axi_araddr == OFF_CTRL) ? ctrl_q :
        (s_axi_araddr == OFF_BUF) ? buf_q :
        (s_axi_araddr == OFF_IRQ_STS) ? {5'h00, sts_q} :
        (s_axi_araddr == OFF_IRQ_MASK) ? {5'h00, mask_q} : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (rd_go)
            begin
                rvalid_q <= 1'b1;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q <= {24'h000000, rd_mux};
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    // Registers seen by software. Hardware sets win over software clears.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q <= CFG_RST;
            ctrl_q <= CTRL_RST;
            sts_q <= 3'h0;
            mask_q <= MASK_RST;
        end
        else
        begin
            if (wsel_status)
                cfg_q <= wbyte[ST_SMP:ST_CKE];
            if (wsel_ctrl)
                ctrl_q <= wbyte | {collide, ovf, 6'h00};
            else
                ctrl_q <= ctrl_q | {collide, ovf, 6'h00};
            sts_q <= (sts_q & ~(wsel_sts ? wbyte[2:0] : 3'h0)) | sts_set;
            if (wsel_mask)
                mask_q <= wbyte[2:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bf_q <= 1'b0;
            buf_q <= BUF_RST;
        end
        else
        begin
            bf_q <= accept | (bf_q & ~rd_buf);
            if (load)
                buf_q <= wbyte;
            else if (accept)
                buf_q <= shreg_next;
        end
    end

    // Shift register and data out.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shreg_q <= 8'h00;
            sdo_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_s;
            if (load)
            begin
                shreg_q <= wbyte;
                if (cke)
                    sdo_q <= wbyte[7];
            end
            else
            begin
                if (do_sample)
                    shreg_q <= shreg_next;
                if (shift_edge)
                    sdo_q <= next_out;
            end
            if (!en || (slave_mode && use_ss && ss_n_s))
                bit_cnt_q <= 3'h0;
            else if (do_sample)
                bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Master clock generator: sixteen toggles plus one closing half period.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mst_q <= MST_IDLE;
            tick_q <= 5'h00;
            div_q <= 5'h00;
            sck_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            case (mst_q)
                MST_IDLE:
                begin
                    sck_q <= clock_idle_polarity;
                    pend_q <= 1'b0;
                    if (load && master)
                    begin
                        mst_q <= MST_RUN;
                        tick_q <= 5'h00;
                        div_q <= half_len - 5'h01;
                    end
                end
                MST_RUN:
                begin
                    if (!master)
                        mst_q <= MST_IDLE;
                    else if (tick)
                    begin
                        div_q <= half_len - 5'h01;
                        pend_q <= sample_edge & sample_point_select;
                        if (tick_q == MST_LAST_TICK)
                            mst_q <= MST_IDLE;
                        else
                        begin
                            sck_q <= ~sck_q;
                            tick_q <= tick_q + 5'h01;
                        end
                    end
                    else
                        div_q <= div_q - 5'h01;
                end
                default:
                    mst_q <= MST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    word_done_a: assert property ((load && master) |-> ##[1:300] done)
        else $error("Master transfer did not complete eight bits.");
    idle_level_a: assert property ((mst_q == MST_IDLE) |=> (sck_o == $past(clock_idle_polarity)))
        else $error("Serial clock left its idle level while idle.");
    pins_on_a: assert property (master |-> (sck_oe && sdo_oe))
        else $error("Master did not drive clock and data out.");
    first_bit_a: assert property ((load && master && cke) |=> (sdo_o == $past(wbyte[7])))
        else $error("First data bit not driven at the load.");
    select_a: assert property ((en && use_ss && ss_n_s) |-> !sdo_oe ##1 (bit_cnt_q == 3'h0))
        else $error("Deselected slave kept driving or counting.");
    hold_buf_a: assert property ((do_sample && !done && !wsel_buf) |=> $stable(buf_q))
        else $error("Buffer changed while a word was still arriving.");
    copy_word_a: assert property ((done && !bf_q) |=>
        (buf_q == $past(shreg_next)) && bf_q && sts_q[IRQ_DONE])
        else $error("Received word not copied or flag not set.");
    load_both_a: assert property (load |=>
        (shreg_q == $past(wbyte)) && (buf_q == $past(wbyte)))
        else $error("Buffer write did not load both registers.");
    collide_a: assert property (collide |=>
        ctrl_q[CT_WCOL] && sts_q[IRQ_WCOL] && (buf_q == $past(buf_q)))
        else $error("Write during a transfer was not refused.");
    status_rd_a: assert property ((rd_go && s_axi_araddr == OFF_STATUS) |=>
        (s_axi_rdata[5:1] == 5'h00) && (s_axi_rdata[7:6] == $past(cfg_q)))
        else $error("Status read returned wrong bits.");
    ctrl_rw_a: assert property (wsel_ctrl |=> (ctrl_q[5:0] == $past(wbyte[5:0])))
        else $error("Control write not stored.");
    edge_out_a: assert property ((shift_edge && !load) |=> (sdo_o == shreg_q[7]))
        else $error("Data out did not change on the selected edge.");
    bf_clear_a: assert property ((rd_buf && !done) |=> !bf_q)
        else $error("Buffer read did not clear buffer full.");
endmodule : ssp_spi_core

// [ssp_peer.sv]
`timescale 1ns/100ps
// Far-side device: a slave to the block's own clock, or a master that runs frames itself.
module ssp_peer (
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic sdo_o,
    output logic sck_i,
    output logic sdi_i,
    output logic ss_n_i
);
    logic pol_q = 1'b0;
    logic cke_q = 1'b0;
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;
    int k = 0;
    initial
    begin
        sck_i = 1'b0;
        sdi_i = 1'b0;
        ss_n_i = 1'b1;
    end
    // Past the last bit the line shows the inverse level, so stale data never passes.
    task automatic next_bit();
        sdi_i = (k < 8) ? tx_q[7 - k] : ~sdi_i;
        k++;
    endtask : next_bit
    task automatic act(input logic sample_point_select);
        if (sample_point_select)
            rx_q = {rx_q[6:0], sdo_o};
        else
            next_bit();
    endtask : act
    task automatic load(input logic [7:0] tx, input logic p, input logic e);
        pol_q = p;
        cke_q = e;
        tx_q = tx;
        rx_q = 8'h00;
        k = 0;
        sck_i = p;
        if (e)
            next_bit();
    endtask : load
    always @(sck_o)
    begin
        if (sck_oe === 1'b1)
            act((sck_o != pol_q) == cke_q);
    end
    // The phase before our sampling edge is the long one; the block's input filter
    // delays its answer by several of its clocks, and a 50 percent duty would race it.
    task automatic xfer(input logic [7:0] tx, input logic p, input logic e,
                        output logic [7:0] rx);
        // Stay off the block's clock edges so no pin races its first flip-flop.
        #25;
        load(tx, p, e);
        #800 ss_n_i = 1'b0;
        #800;
        repeat (8)
        begin
            #(e ? 560 : 240) sck_i = ~p;
            act(e);
            #(e ? 240 : 560) sck_i = p;
            act(!e);
        end
        #800 ss_n_i = 1'b1;
        sdi_i = ~sdi_i;
        rx = rx_q;
    endtask : xfer
endmodule : ssp_peer

// [ssp_tb.sv]
`timescale 1ns/100ps
module tb
    import ssp_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic sck_i, sck_o, sck_oe, sdi_i, sdo_o, sdo_oe, ss_n_i;
    int fails = 0;
    int checks = 0;
    always #50 aclk = ~aclk;
    ssp_spi_core dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .ss_n_i(ss_n_i)
    );
    ssp_peer peer_u (
        .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sck_i(sck_i), .sdi_i(sdi_i),
        .ss_n_i(ss_n_i)
    );
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("write response", {30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(what, rdata, {24'h000000, exp});
        chk("read response", {30'h0, rresp}, {30'h0, er});
    endtask : rd
    task automatic t_regs();
        rd(OFF_STATUS, {CFG_RST, 6'h00}, "status reset");
        rd(OFF_CTRL, CTRL_RST, "control reset");
        rd(OFF_BUF, BUF_RST, "buffer reset");
        rd(OFF_IRQ_MASK, {5'h00, MASK_RST}, "mask reset");
        wr(OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, 8'hC0, "status rw bits");
        wr(OFF_CTRL, 8'h1A);
        rd(OFF_CTRL, 8'h1A, "control rw");
        wr(OFF_CTRL, 8'h00);
        wr(OFF_STATUS, 8'h00);
        wr(8'h40, 8'h55, RESP_SLVERR);
        rd(8'h40, 8'h00, "unmapped read", RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs
    task automatic t_master();
        wr(OFF_IRQ_MASK, 8'h01);
        for (logic [2:0] c = 3'h0; c < 3'h4; c++)
        begin
            wr(OFF_STATUS, {c[1], c[0], 6'h00});
            wr(OFF_CTRL, {2'b00, 1'b1, c[1], 4'h3});
            peer_u.load(8'hA5 ^ {5'h00, c}, c[1], c[0]);
            wr(OFF_BUF, 8'h3C + {5'h00, c});
            if (c == 3'h3)
                wr(OFF_BUF, 8'hFF);
            while (irq !== 1'b1)
                @(posedge aclk);
            // The run closes at most two half periods of 16 cycles after the last sample.
            repeat (32)
                @(posedge aclk);
            chk("clock idle", {31'h0, sck_o}, {31'h0, c[1]});
            chk("clock drive", {31'h0, sck_oe}, 32'h1);
            rd(OFF_STATUS, {c[1], c[0], 6'h01}, "full set");
            rd(OFF_BUF, 8'hA5 ^ {5'h00, c}, "master rx");
            rd(OFF_STATUS, {c[1], c[0], 6'h00}, "full cleared");
            chk("peer rx", {24'h0, peer_u.rx_q}, {24'h0, 8'h3C + {5'h00, c}});
            rd(OFF_IRQ_STS, (c == 3'h3) ? 8'h05 : 8'h01, "irq status");
            wr(OFF_IRQ_STS, 8'h07);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        wr(OFF_CTRL, 8'h00);
        $display("test master done");
    endtask : t_master
    task automatic t_slave();
        logic [7:0] rx;
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_STATUS, 8'h40);
        wr(OFF_CTRL, {4'h2, MODE_SLAVE_SS});
        wr(OFF_BUF, 8'hC3);
        chk("deselected out", {31'h0, sdo_oe}, 32'h0);
        peer_u.xfer(8'h5A, 1'b0, 1'b1, rx);
        chk("slave tx", {24'h0, rx}, 32'hC3);
        rd(OFF_STATUS, 8'h41, "slave full");
        chk("irq masked", {31'h0, irq}, 32'h0);
        peer_u.xfer(8'h96, 1'b0, 1'b1, rx);
        rd(OFF_CTRL, {4'h6, MODE_SLAVE_SS}, "overflow");
        rd(OFF_IRQ_STS, 8'h03, "slave irq status");
        wr(OFF_IRQ_MASK, 8'h02);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STS, 8'h03);
        chk("irq dropped", {31'h0, irq}, 32'h0);
        rd(OFF_BUF, 8'h5A, "first word kept");
        peer_u.load(8'h7E, 1'b1, 1'b0);
        wr(OFF_STATUS, 8'h00);
        wr(OFF_CTRL, {4'h3, MODE_SLAVE_NOSS});
        wr(OFF_BUF, 8'h81);
        peer_u.xfer(8'h7E, 1'b1, 1'b0, rx);
        chk("slave tx mode", {24'h0, rx}, 32'h81);
        rd(OFF_BUF, 8'h7E, "slave rx mode");
        $display("test slave done");
    endtask : t_slave
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        repeat (20)
            @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_master();
        t_slave();
        print_verdict();
    end
    // The tests need under two thousand cycles; ten times that means a hang.
    initial
    begin
        repeat (20000)
            @(posedge aclk);
        fails++;
        print_verdict();
    end
endmodule : tb
